// *** design/rgwdt_defines.vh ***
// Operation
// - 16-bit down-counter requests system reset on underflow while enabled.
// - Wait mode freezes counting when control bit 3 is set.
// - Doze mode freezes counting when control bit 2 is set.
// - Stop mode always freezes; counting resumes from held state.
// - Halted mode freezes when bit 1 set; updates made while halted remain.
// - While halted all registers read and write normally, even locked fields; only a cleared enable bit cannot be set again.
// - First write while halted does not lock the field.
// - Halt-stop bit changes while halted start or stop counting.
// - Outside halted mode each control field locks after its first write.
// - Enable clear holds counter and prescaler stopped; no reset request.
// - Once disabled, the watchdog cannot be enabled again until reset.
// - 32-bit accesses get a bus error; 8- and 16-bit accepted.
// - Writes to unassigned offsets and reserved bits are ignored.
// - Writing first key then second key reloads counter from modulus.
// - Any other service value restarts the key sequence.
// - Modulus write loads counter at once and clears prescaler.
// - On timeout the reset controller is signalled.
`ifndef RGWDT_DEFINES_VH
`define RGWDT_DEFINES_VH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define RGWDT_OFS_CONTROL 32'hFC08C000
`define RGWDT_OFS_MODULUS 32'hFC08C002
`define RGWDT_OFS_COUNT 32'hFC08C004
`define RGWDT_OFS_SERVICE 32'hFC08C006
`define RGWDT_OFS_IRQ_STAT 32'hFC08C008
`define RGWDT_OFS_IRQ_EN 32'hFC08C00A
`define RGWDT_OFS_IRQ_CLR 32'hFC08C00C

// ****************************************
// Control fields and reset values
// ****************************************
`define RGWDT_BIT_EN 0
`define RGWDT_BIT_HALT 1
`define RGWDT_BIT_DOZE 2
`define RGWDT_BIT_WAIT 3
`define RGWDT_CTRL_RST 4'hF
`define RGWDT_MOD_RST 16'hFFFF
`define RGWDT_KEY1 16'h5555
`define RGWDT_KEY2 16'hAAAA

// ****************************************
// Access sizes and timing
// ****************************************
`define RGWDT_SZ_BYTE 2'h0
`define RGWDT_SZ_HALF 2'h1
`define RGWDT_SZ_WORD 2'h2
`define RGWDT_PRESCALE 4096

// Interrupt status bits
`define RGWDT_IRQ_TIMEOUT 0
`define RGWDT_IRQ_SERVICED 1
`define RGWDT_IRQ_BADKEY 2

`endif

// *** design/rgwdt_top.v ***
`timescale 1ns/1ps
`default_nettype none
`include "rgwdt_defines.vh"

module rgwdt_top #(
    parameter PRESCALE = `RGWDT_PRESCALE
) (
    // Clock and reset
    input wire sys_clk,
    input wire sys_rst,
    // Register port
    input wire [31:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire [1:0] reg_size,
    input wire reg_wr,
    input wire reg_rd,
    output reg [15:0] reg_rdata,
    output reg reg_err,
    // Power and debug mode levels (from other clock logic)
    input wire mode_wait,
    input wire mode_doze,
    input wire mode_stop,
    input wire mode_halted,
    // Reset controller and interrupt
    output reg wd_reset_req,
    output reg irq
);

    // ****************************************
    // Mode synchronisers
    // ****************************************
    reg [3:0] mode_s1_q;
    reg [3:0] mode_s2_q;

    // Two flops before any logic reads the mode levels
    always @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            mode_s1_q <= 4'h0;
            mode_s2_q <= 4'h0;
        end
        else
        begin
            mode_s1_q <= {mode_halted, mode_stop, mode_doze, mode_wait};
            mode_s2_q <= mode_s1_q;
        end
    end

    wire in_wait = mode_s2_q[0];
    wire in_doze = mode_s2_q[1];
    wire in_stop = mode_s2_q[2];
    wire in_halt = mode_s2_q[3];

    // ****************************************
    // State
    // ****************************************
    reg [3:0] ctrl_q;
    reg [3:0] lock_q;
    reg [15:0] mod_q;
    reg mod_lock_q;
    reg [15:0] cnt_q;
    reg [11:0] pre_q;
    reg key1_seen_q;
    reg [15:0] svc_q;
    reg [2:0] irq_stat_q;
    reg [2:0] irq_en_q;

    // Byte lane write mask for 8-bit accesses at even/odd byte
    function [15:0] lane_mask;
        input [1:0] size;
        input a0;
        begin
            if (size == `RGWDT_SZ_BYTE)
                lane_mask = a0 ? 16'h00FF : 16'hFF00;
            else
                lane_mask = 16'hFFFF;
        end
    endfunction

    // Merge write data into a register under a byte mask
    function [15:0] merge;
        input [15:0] old;
        input [15:0] nw;
        input [15:0] m;
        begin
            merge = (old & ~m) | (nw & m);
        end
    endfunction

    wire [31:0] word_addr = {reg_addr[31:1], 1'b0};
    wire size_ok = (reg_size != `RGWDT_SZ_WORD);
    wire wr_ok = reg_wr & size_ok;
    wire [15:0] wmask = lane_mask(reg_size, reg_addr[0]);
    wire wr_ctrl = wr_ok && (word_addr == `RGWDT_OFS_CONTROL);
    wire wr_mod = wr_ok && (word_addr == `RGWDT_OFS_MODULUS);
    wire wr_svc = wr_ok && (word_addr == `RGWDT_OFS_SERVICE);
    wire wr_en = wr_ok && (word_addr == `RGWDT_OFS_IRQ_EN);
    wire wr_clr = wr_ok && (word_addr == `RGWDT_OFS_IRQ_CLR);

    // Control bits are in the low byte; a write touches them only if that lane is on
    wire ctrl_lane = wmask[0];
    wire [3:0] ctrl_wr_val = reg_wdata[3:0];

    // Service value after merging partial writes
    wire [15:0] svc_val = merge(svc_q, reg_wdata, wmask);
    wire is_key1 = wr_svc && (svc_val == `RGWDT_KEY1);
    wire is_key2 = wr_svc && (svc_val == `RGWDT_KEY2);

    // Counting gate
    wire enabled = ctrl_q[`RGWDT_BIT_EN];
    wire frozen = in_stop
        | (in_wait & ctrl_q[`RGWDT_BIT_WAIT])
        | (in_doze & ctrl_q[`RGWDT_BIT_DOZE])
        | (in_halt & ctrl_q[`RGWDT_BIT_HALT]);
    wire run = enabled & ~frozen;
    wire pre_wrap = (pre_q == PRESCALE[11:0] - 12'h001);
    wire underflow = run & pre_wrap & (cnt_q == 16'h0000);
    wire reload = is_key2 & key1_seen_q;

    // ****************************************
    // Control register with write-once locks
    // ****************************************
    integer i;
    reg [3:0] ctrl_d;
    reg [3:0] lock_d;
    always @*
    begin
        ctrl_d = ctrl_q;
        lock_d = lock_q;
        for (i = 0; i < 4; i = i + 1)
        begin
            if (wr_ctrl && ctrl_lane && (in_halt || !lock_q[i]))
            begin
                ctrl_d[i] = ctrl_wr_val[i];
                if (!in_halt)
                    lock_d[i] = 1'b1;
            end
        end
        // Never re-enable once disabled
        if (!ctrl_q[`RGWDT_BIT_EN])
            ctrl_d[`RGWDT_BIT_EN] = 1'b0;
    end

    always @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ctrl_q <= `RGWDT_CTRL_RST;
            lock_q <= 4'h0;
        end
        else
        begin
            ctrl_q <= ctrl_d;
            lock_q <= lock_d;
        end
    end

    // ****************************************
    // Modulus register, write-once
    // ****************************************
    wire mod_write = wr_mod && (in_halt || !mod_lock_q);
    wire [15:0] mod_new = merge(mod_q, reg_wdata, wmask);
    always @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            mod_q <= `RGWDT_MOD_RST;
            mod_lock_q <= 1'b0;
        end
        else if (mod_write)
        begin
            mod_q <= mod_new;
            if (!in_halt)
                mod_lock_q <= 1'b1;
        end
    end

    // ****************************************
    // Service key sequence
    // ****************************************
    always @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            svc_q <= 16'h0000;
            key1_seen_q <= 1'b0;
        end
        else if (wr_svc)
        begin
            svc_q <= svc_val;
            if (is_key1)
                key1_seen_q <= 1'b1;
            else if (is_key2)
                key1_seen_q <= 1'b0;
            else
                key1_seen_q <= 1'b0;
        end
    end

    // ****************************************
    // Prescaler and counter
    // ****************************************
    always @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            pre_q <= 12'h000;
            cnt_q <= `RGWDT_MOD_RST;
        end
        else if (mod_write)
        begin
            cnt_q <= mod_new;
            pre_q <= 12'h000;
        end
        else if (reload)
        begin
            cnt_q <= mod_q;
            pre_q <= 12'h000;
        end
        else if (run)
        begin
            if (pre_wrap)
            begin
                pre_q <= 12'h000;
                cnt_q <= cnt_q - 16'h0001;
            end
            else
                pre_q <= pre_q + 12'h001;
        end
    end

    // ****************************************
    // Reset request and interrupts
    // ****************************************
    wire [2:0] irq_evt = {wr_svc & ~is_key1 & ~is_key2, reload, underflow};
    wire [2:0] clr_bits = wr_clr ? reg_wdata[2:0] : 3'h0;
    always @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            wd_reset_req <= 1'b0;
            irq_stat_q <= 3'h0;
            irq_en_q <= 3'h0;
            irq <= 1'b0;
        end
        else
        begin
            // Request stays until system reset arrives
            if (underflow)
                wd_reset_req <= 1'b1;
            // Set beats clear
            irq_stat_q <= (irq_stat_q & ~clr_bits) | irq_evt;
            if (wr_en)
                irq_en_q <= reg_wdata[2:0];
            irq <= |(((irq_stat_q & ~clr_bits) | irq_evt) & (wr_en ? reg_wdata[2:0] : irq_en_q));
        end
    end

    // ****************************************
    // Read port and bus error
    // ****************************************
    reg [15:0] rd_d;
    always @*
    begin
        case (word_addr)
            `RGWDT_OFS_CONTROL: rd_d = {12'h000, ctrl_q};
            `RGWDT_OFS_MODULUS: rd_d = mod_q;
            `RGWDT_OFS_COUNT: rd_d = cnt_q;
            `RGWDT_OFS_SERVICE: rd_d = svc_q;
            `RGWDT_OFS_IRQ_STAT: rd_d = {13'h0000, irq_stat_q};
            `RGWDT_OFS_IRQ_EN: rd_d = {13'h0000, irq_en_q};
            default: rd_d = 16'h0000;
        endcase
    end

    always @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            reg_rdata <= 16'h0000;
            reg_err <= 1'b0;
        end
        else
        begin
            reg_rdata <= (reg_rd && size_ok) ? rd_d : 16'h0000;
            reg_err <= (reg_rd | reg_wr) & ~size_ok;
        end
    end

endmodule // rgwdt_top
`default_nettype wire

// *** test/wt_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "rgwdt_defines.vh"
module wt_properties (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Register port
    input wire logic [31:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic [1:0] reg_size,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic reg_err,
    // Mode levels
    input wire logic mode_wait,
    input wire logic mode_doze,
    input wire logic mode_stop,
    input wire logic mode_halted,
    // Reset request and interrupt
    input wire logic wd_reset_req,
    input wire logic irq
);
    // ****************************************
    // Checks on the register port and outputs
    // ****************************************
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    logic rd_ctl_q, off_q;
    // Notes that a control read showed the enable bit clear
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rd_ctl_q <= 1'h0;
            off_q <= 1'h0;
        end
        else
        begin
            rd_ctl_q <= reg_rd && reg_addr == `RGWDT_OFS_CONTROL && reg_size != 2'h2;
            if (rd_ctl_q && !reg_rdata[0])
                off_q <= 1'h1;
        end
    end
    a_err_word: assert property ((reg_wr || reg_rd) && reg_size == 2'h2 |=> reg_err)
        else $error("no bus error after word access");
    a_err_only: assert property (!((reg_wr || reg_rd) && reg_size == 2'h2) |=> !reg_err)
        else $error("bus error without word access");
    a_word_quiet: assert property (reg_rd && reg_size == 2'h2 |=> reg_rdata == 16'h0000)
        else $error("word read returned data");
    a_rsvd_zero: assert property (rd_ctl_q |-> reg_rdata[15:4] == 12'h000)
        else $error("reserved control bits read nonzero");
    a_hole_zero: assert property (reg_rd && reg_addr == 32'hFC08C00E |=> reg_rdata == 16'h0000)
        else $error("unassigned offset read nonzero");
    a_req_holds: assert property (wd_reset_req |=> wd_reset_req)
        else $error("reset request dropped");
    a_stop_freeze: assert property (mode_stop [*4] |=> !$rose(wd_reset_req))
        else $error("reset request while stopped");
    a_stays_off: assert property (rd_ctl_q && off_q |-> !reg_rdata[0])
        else $error("watchdog enabled again");
    a_off_quiet: assert property (off_q |=> !$rose(wd_reset_req))
        else $error("reset request while disabled");
    // Main scenarios reached
    c_err: cover property (reg_err);
    c_req: cover property ($rose(wd_reset_req));
    c_irq: cover property (irq);
endmodule // wt_properties
bind rgwdt_top wt_properties i_chk (.sys_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_size,
    .reg_wr, .reg_rd, .reg_rdata, .reg_err, .mode_wait, .mode_doze, .mode_stop,
    .mode_halted, .wd_reset_req, .irq);
`default_nettype wire

// *** test/watchdog_timer_test.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "rgwdt_defines.vh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_total++; \
    $display("wrong value at %0t got %h exp %h", $time, g, e); end end
module watchdog_timer_test;
    // ****************************************
    // Stimulus and checks
    // ****************************************
    localparam [31:0] ad_ctl = `RGWDT_OFS_CONTROL;
    localparam [31:0] ad_mod = `RGWDT_OFS_MODULUS;
    localparam [31:0] ad_cnt = `RGWDT_OFS_COUNT;
    localparam [31:0] ad_svc = `RGWDT_OFS_SERVICE;
    logic sys_clk = 1'h0, sys_rst = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0;
    logic mode_wait = 1'h0, mode_doze = 1'h0, mode_stop = 1'h0, mode_halted = 1'h0;
    logic [31:0] reg_addr = 32'h0;
    logic [15:0] reg_wdata = 16'h0, got, keep;
    logic [1:0] reg_size = 2'h1;
    wire [15:0] reg_rdata;
    wire reg_err, wd_reset_req, irq;
    int err_total = 0, checks = 0, cyc = 0;
    rgwdt_top #(.PRESCALE(8)) i_dut (.sys_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_size,
        .reg_wr, .reg_rd, .reg_rdata, .reg_err, .mode_wait, .mode_doze, .mode_stop,
        .mode_halted, .wd_reset_req, .irq);
    // Clock and hang guard
    always #10 sys_clk = ~sys_clk;
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_total++;
            results();
        end
    end
    task results();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task wr(input logic [31:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        @(posedge sys_clk);
        reg_wr <= 1'h0;
    endtask
    task rd(input logic [31:0] a);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'h1;
        @(posedge sys_clk);
        reg_rd <= 1'h0;
        @(negedge sys_clk);
        got = reg_rdata;
    endtask
    task wt(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task rst();
        @(posedge sys_clk);
        sys_rst <= 1'h1;
        {mode_wait, mode_doze, mode_stop, mode_halted} <= 4'h0;
        wt(10);
        sys_rst <= 1'h0;
    endtask
    task wait_req();
        for (int n = 0; n < 60 && wd_reset_req !== 1'h1; n++)
            @(posedge sys_clk);
    endtask
    task t_regs();
        rst();
        rd(ad_ctl); `CHK(got, 16'h000F)
        rd(ad_mod); `CHK(got, 16'hFFFF)
        rd(ad_cnt); `CHK(got, 16'hFFFF)
        rd(ad_svc); `CHK(got, 16'h0000)
        reg_size <= 2'h2;
        wr(ad_mod, 16'h0001);
        reg_size <= 2'h1;
        rd(ad_mod); `CHK(got, 16'hFFFF)
        wr(32'hFC08C00E, 16'h1234);
        rd(32'hFC08C00E); `CHK(got, 16'h0000)
        $display("regs done");
    endtask
    task t_service();
        rst();
        wr(ad_mod, 16'h0004);
        rd(ad_cnt); `CHK(got, 16'h0004)
        wt(20);
        wr(ad_svc, `RGWDT_KEY1);
        wr(`RGWDT_OFS_IRQ_EN, 16'h0000);
        wr(ad_svc, `RGWDT_KEY2);
        rd(ad_cnt); `CHK(got, 16'h0004)
        wr(ad_svc, `RGWDT_KEY1);
        wr(ad_svc, 16'h1234);
        wr(ad_svc, `RGWDT_KEY2);
        wt(12);
        // Two prescaler wraps since the good reload; a bad reload would leave one
        rd(ad_cnt); `CHK(got, 16'h0002)
        $display("service done");
    endtask
    task t_timeout();
        rst();
        wr(ad_mod, 16'h0001);
        wt(8); `CHK(wd_reset_req, 1'h0)
        wait_req(); `CHK(wd_reset_req, 1'h1)
        wt(2); `CHK(irq, 1'h0)
        wr(`RGWDT_OFS_IRQ_EN, 16'h0001);
        wt(2); `CHK(irq, 1'h1)
        wr(`RGWDT_OFS_IRQ_CLR, 16'h0001);
        wt(2); `CHK(irq, 1'h0)
        $display("timeout done");
    endtask
    task t_modes();
        for (int m = 0; m < 3; m++)
        begin
            rst();
            wr(ad_mod, 16'h0003);
            {mode_stop, mode_doze, mode_wait} <= 3'h1 << m;
            wt(60); `CHK(wd_reset_req, 1'h0)
            rd(ad_cnt); `CHK(got, 16'h0003)
            {mode_stop, mode_doze, mode_wait} <= 3'h0;
            wait_req(); `CHK(wd_reset_req, 1'h1)
        end
        rst();
        wr(ad_ctl, 16'h0001);
        wr(ad_ctl, 16'h000F);
        rd(ad_ctl); `CHK(got, 16'h0001)
        wr(ad_mod, 16'h0003);
        {mode_wait, mode_doze} <= 2'h3;
        wt(60); `CHK(wd_reset_req, 1'h1)
        $display("modes done");
    endtask
    task t_disable();
        rst();
        wr(ad_mod, 16'h0002);
        wr(ad_ctl, 16'h000E);
        wr(ad_ctl, 16'h000F);
        rd(ad_ctl); `CHK(got, 16'h000E)
        wt(60); `CHK(wd_reset_req, 1'h0)
        rd(ad_cnt); `CHK(got, 16'h0002)
        $display("disable done");
    endtask
    task t_halt();
        rst();
        wr(ad_mod, 16'h0010);
        mode_halted <= 1'h1;
        wt(40);
        rd(ad_cnt); `CHK(got, 16'h0010)
        wr(ad_ctl, 16'h000D);
        rd(ad_ctl); `CHK(got, 16'h000D)
        wt(30);
        rd(ad_cnt); `CHK(got < 16'h0010, 1'h1)
        wr(ad_ctl, 16'h000F);
        wt(4);
        rd(ad_cnt);
        keep = got;
        wt(30);
        rd(ad_cnt); `CHK(got, keep)
        mode_halted <= 1'h0;
        wt(4);
        wr(ad_ctl, 16'h0009);
        rd(ad_ctl); `CHK(got, 16'h0009)
        wr(ad_ctl, 16'h000F);
        rd(ad_ctl); `CHK(got, 16'h0009)
        $display("halt done");
    endtask
    // Main sequence
    initial
    begin
        t_regs();
        t_service();
        t_timeout();
        t_modes();
        t_disable();
        t_halt();
        results();
    end
endmodule // watchdog_timer_test
`default_nettype wire
